// file: logic/alarm_cfg_pkg.sv
`default_nettype none
package alarm_cfg_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 8;          // 125 MHz system clock
  localparam int TICK_NS = 1000000;          // Millisecond time base
  localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;
  localparam int AF_DLY0_S = 300;            // Airflow delay, normal
  localparam int AF_DLY1_MIN = 10;
  localparam int AF_DLY2_MIN = 20;
  localparam int AF_DLY3_S = 10;             // Test position
  localparam int AF_DLY0_MS = AF_DLY0_S * 1000;
  localparam int AF_DLY1_MS = AF_DLY1_MIN * 60000;
  localparam int AF_DLY2_MS = AF_DLY2_MIN * 60000;
  localparam int AF_DLY3_MS = AF_DLY3_S * 1000;
  localparam int INV_DLY1_MS = 3000;         // Until indicators flash
  localparam int INV_DLY2_MS = 3000;         // Then until fault
  localparam int TMR_W = 22;                 // Holds 20 min in ms
  // ----------------------------------------
  // Airflow tolerance in percent
  // ----------------------------------------
  localparam logic [7:0] TOL_OFF_OFF = 8'h14; // 20
  localparam logic [7:0] TOL_OFF_ON = 8'h1e;  // 30
  localparam logic [7:0] TOL_ON_OFF = 8'h32;  // 50
  localparam logic [7:0] TOL_ON_ON = 8'h0a;   // 10
  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_CMD = 8'h04;
  localparam logic [7:0] ADDR_STATE = 8'h08;
  localparam logic [7:0] ADDR_INT_STAT = 8'h0c;
  localparam logic [7:0] ADDR_INT_MASK = 8'h10;
  localparam logic [15:0] CONFIG_RST = 16'h0000;
  localparam logic [4:0] INT_MASK_RST = 5'h00;
  // Config fields
  localparam int CF_AIRFLOW = 0;             // [3:0] airflow switches
  localparam int CF_RELAY = 4;               // [7:4] output switches
  localparam int CF_CLASS = 8;               // [11:8] class switch
  localparam int CF_HOLES = 12;              // [15:12] holes switch
  localparam logic [3:0] CLASS_FIX_LO = 4'ha;
  localparam logic [3:0] CLASS_FIX_HI = 4'hf;
  localparam logic [3:0] HOLES_FIX_LO = 4'h1;
  localparam logic [3:0] HOLES_FIX_HI = 4'hc;
  // Interrupt event bits
  localparam int EV_ALARM = 0;
  localparam int EV_FAULT = 1;
  localparam int EV_PRE = 2;
  localparam int EV_AIRFLOW = 3;
  localparam int EV_INVALID = 4;

  // Detector criteria, all active high levels
  typedef struct packed {
    logic alarm;
    logic [2:0] preSig;
    logic sensDust;
    logic sensDirt;
    logic sensFault;
    logic pipeBlock;
    logic pipeBreak;
    logic fanFault;
    logic initFault;
    logic underVolt;
    logic clockFault;
  } crit_t;

  // Outward signalling
  typedef struct packed {
    logic ocAlarm;
    logic ocFault;
    logic [4:0] relay;
    logic indFlash;
  } outs_t;
endpackage
`default_nettype wire

// file: logic/alarm_fault_output_config.sv
`timescale 1ns/1ps
`default_nettype none
module alarm_fault_output_config #(
  parameter int TICK_CYCLES = alarm_cfg_pkg::TICK_CYC,
  parameter int AF_DLY0 = alarm_cfg_pkg::AF_DLY0_MS,
  parameter int AF_DLY1 = alarm_cfg_pkg::AF_DLY1_MS,
  parameter int AF_DLY2 = alarm_cfg_pkg::AF_DLY2_MS,
  parameter int AF_DLY3 = alarm_cfg_pkg::AF_DLY3_MS,
  parameter int INV_DLY1 = alarm_cfg_pkg::INV_DLY1_MS,
  parameter int INV_DLY2 = alarm_cfg_pkg::INV_DLY2_MS
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Detector side
  input wire alarm_cfg_pkg::crit_t crit,
  input wire logic [7:0] flowDevPct,
  input wire logic comboBad,
  input wire logic extReset,
  // Outward
  output alarm_cfg_pkg::outs_t outs,
  output logic irq
);
  // ----------------------------------------
  // Local helpers
  // ----------------------------------------
  localparam int TW = alarm_cfg_pkg::TMR_W;

  // Tolerance from switches 1 and 2
  function automatic logic [7:0] tolPct(input logic sw1, input logic sw2);
    case ({sw1, sw2})
      2'b00: tolPct = alarm_cfg_pkg::TOL_OFF_OFF;
      2'b01: tolPct = alarm_cfg_pkg::TOL_OFF_ON;
      2'b10: tolPct = alarm_cfg_pkg::TOL_ON_OFF;
      default: tolPct = alarm_cfg_pkg::TOL_ON_ON;
    endcase
  endfunction

  // Delay in ms from switches 3 and 4
  function automatic logic [TW-1:0] dlyMs(input logic sw3, input logic sw4);
    case ({sw3, sw4})
      2'b00: dlyMs = TW'(AF_DLY0);
      2'b01: dlyMs = TW'(AF_DLY1);
      2'b10: dlyMs = TW'(AF_DLY2);
      default: dlyMs = TW'(AF_DLY3);
    endcase
  endfunction

  // Address hit, used by both the read and write decoders
  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [15:0] config_r, config_nxt;       // Switch settings
  logic [4:0] intStat_r, intStat_nxt;      // Sticky events
  logic [4:0] intMask_r, intMask_nxt;      // Event enables
  logic [31:0] prdata_r, prdata_nxt;       // Read data
  logic [4:0] evPrev_r, evPrev_nxt;        // For edge detection
  logic [$clog2(TICK_CYCLES)-1:0] div_r, div_nxt;
  logic [15:0] stateWord;
  logic wrAcc, rdSetup, mapped, clrCmd, clrAll, tick;
  logic [4:0] evNow, evRise;

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  // Zero wait states: read data is captured in the setup cycle, write data in the access cycle
  assign pready = 1'b1;
  assign wrAcc = psel && penable && pwrite && mapped;
  assign rdSetup = psel && !penable && !pwrite;
  assign prdata = prdata_r;

  // Unmapped addresses answer with an error
  always_comb begin
    if (hit(paddr, alarm_cfg_pkg::ADDR_CONFIG)) begin
      mapped = 1'b1;
    end else if (hit(paddr, alarm_cfg_pkg::ADDR_CMD)) begin
      mapped = 1'b1;
    end else if (hit(paddr, alarm_cfg_pkg::ADDR_STATE)) begin
      mapped = 1'b1;
    end else if (hit(paddr, alarm_cfg_pkg::ADDR_INT_STAT)) begin
      mapped = 1'b1;
    end else if (hit(paddr, alarm_cfg_pkg::ADDR_INT_MASK)) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  end
  assign pslverr = psel && penable && !mapped;

  // Clear command: bit 0 of the command word or the external input
  assign clrCmd = wrAcc && hit(paddr, alarm_cfg_pkg::ADDR_CMD) && pwdata[0];
  assign clrAll = clrCmd || extReset;

  // ----------------------------------------
  // Millisecond divider
  // ----------------------------------------
  always_comb begin
    div_nxt = div_r + 1'b1;
    if (tick) begin
      div_nxt = '0;
    end
  end
  assign tick = (div_r == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1));

  // ----------------------------------------
  // Airflow supervision
  // ----------------------------------------
  logic [3:0] afSw;
  logic flowOut, afFault;
  assign afSw = config_r[alarm_cfg_pkg::CF_AIRFLOW +: 4];
  // Window width from switches 1 and 2
  assign flowOut = flowDevPct > tolPct(afSw[0], afSw[1]);

  // Fault once the deviation has lasted the selected delay, less up to one tick
  delay_timer u_afTimer (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .tick(tick),
    .run(flowOut),
    .limit(dlyMs(afSw[2], afSw[3])),
    .expired(afFault)
  );

  // ----------------------------------------
  // Rotary switch check
  // ----------------------------------------
  logic [3:0] classSw, holesSw;
  logic fixedSet, invFlash, invFault;
  assign classSw = config_r[alarm_cfg_pkg::CF_CLASS +: 4];
  assign holesSw = config_r[alarm_cfg_pkg::CF_HOLES +: 4];
  // Fixed parameter set for A..F with 1..C, else calculated
  assign fixedSet = (classSw >= alarm_cfg_pkg::CLASS_FIX_LO)
    && (classSw <= alarm_cfg_pkg::CLASS_FIX_HI)
    && (holesSw >= alarm_cfg_pkg::HOLES_FIX_LO)
    && (holesSw <= alarm_cfg_pkg::HOLES_FIX_HI);

  // First stage: flashing after one delay
  delay_timer u_invFlash (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .tick(tick),
    .run(comboBad),
    .limit(TW'(INV_DLY1)),
    .expired(invFlash)
  );

  // Second stage starts only once flashing has begun
  delay_timer u_invFault (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .tick(tick),
    .run(invFlash),
    .limit(TW'(INV_DLY2)),
    .expired(invFault)
  );

  // ----------------------------------------
  // Fault aggregation and latching
  // ----------------------------------------
  logic [3:0] relSw;
  logic sensAny, pipeAny, faultCond, alarmSt, faultSt;
  logic [2:0] preSt;
  assign relSw = config_r[alarm_cfg_pkg::CF_RELAY +: 4];
  assign sensAny = crit.sensDust | crit.sensDirt | crit.sensFault;
  assign pipeAny = crit.pipeBlock | crit.pipeBreak | afFault;
  // Every fault event, including setting errors
  assign faultCond = sensAny | pipeAny | crit.fanFault | crit.initFault
    | crit.underVolt | crit.clockFault | invFault;

  latch_cell #(.W(1)) u_alarmSt (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .latchEn(relSw[0]),
    .clr(clrAll),
    .cond(crit.alarm),
    .state(alarmSt)
  );
  latch_cell #(.W(1)) u_faultSt (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .latchEn(relSw[1]),
    .clr(clrAll),
    .cond(faultCond),
    .state(faultSt)
  );
  latch_cell #(.W(3)) u_preSt (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .latchEn(relSw[2]),
    .clr(clrAll),
    .cond(crit.preSig),
    .state(preSt)
  );

  // ----------------------------------------
  // Output mapping
  // ----------------------------------------
  logic [4:0] relayMap;
  always_comb begin
    if (relSw[3]) begin
      // Alternative assignment for panels without pre-signals
      relayMap = {faultSt, {2{alarmSt | faultSt}}, {2{alarmSt}}};
    end else begin
      // Relay 5 includes the fan with the pipe faults
      relayMap = {pipeAny | crit.fanFault, sensAny, preSt};
    end
  end

  // Registered outward signals
  alarm_cfg_pkg::outs_t outs_r, outs_nxt;
  always_comb begin
    outs_nxt.ocAlarm = alarmSt;
    outs_nxt.ocFault = faultSt;
    outs_nxt.relay = relayMap;
    outs_nxt.indFlash = invFlash;
  end
  assign outs = outs_r;

  // ----------------------------------------
  // Register next values
  // ----------------------------------------
  assign evNow = {invFlash, afFault, |preSt, faultSt, alarmSt};
  assign evRise = evNow & ~evPrev_r;
  assign stateWord = {3'h0, fixedSet, invFault, invFlash, afFault,
    preSt, faultSt, alarmSt, relSw};
  assign irq = |(intStat_r & intMask_r);

  always_comb begin
    config_nxt = config_r;
    intMask_nxt = intMask_r;
    intStat_nxt = intStat_r;
    evPrev_nxt = evNow;
    prdata_nxt = prdata_r;
    if (wrAcc && hit(paddr, alarm_cfg_pkg::ADDR_CONFIG)) begin
      config_nxt = pwdata[15:0];
    end
    if (wrAcc && hit(paddr, alarm_cfg_pkg::ADDR_INT_MASK)) begin
      intMask_nxt = pwdata[4:0];
    end
    if (wrAcc && hit(paddr, alarm_cfg_pkg::ADDR_INT_STAT)) begin
      intStat_nxt = intStat_r & ~pwdata[4:0];
    end
    // A new event wins over a simultaneous clear
    intStat_nxt = intStat_nxt | evRise;
    if (rdSetup) begin
      if (hit(paddr, alarm_cfg_pkg::ADDR_CONFIG)) begin
        prdata_nxt = {16'h0000, config_r};
      end else if (hit(paddr, alarm_cfg_pkg::ADDR_STATE)) begin
        prdata_nxt = {11'h000, outs_r.relay, stateWord};
      end else if (hit(paddr, alarm_cfg_pkg::ADDR_INT_STAT)) begin
        prdata_nxt = {27'h0000000, intStat_r};
      end else if (hit(paddr, alarm_cfg_pkg::ADDR_INT_MASK)) begin
        prdata_nxt = {27'h0000000, intMask_r};
      end else begin
        prdata_nxt = 32'h00000000;
      end
    end
  end

  // Only registering here
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      config_r <= alarm_cfg_pkg::CONFIG_RST;
      intMask_r <= alarm_cfg_pkg::INT_MASK_RST;
      intStat_r <= '0;
      evPrev_r <= '0;
      prdata_r <= '0;
      div_r <= '0;
      outs_r <= '0;
    end else begin
      config_r <= config_nxt;
      intMask_r <= intMask_nxt;
      intStat_r <= intStat_nxt;
      evPrev_r <= evPrev_nxt;
      prdata_r <= prdata_nxt;
      div_r <= div_nxt;
      outs_r <= outs_nxt;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_clear;
    clrAll;
  endsequence
  sequence s_alarmGone;
    !crit.alarm [*2];
  endsequence

  property p_ocAlarm;
    crit.alarm |-> ##2 outs.ocAlarm;
  endproperty
  a_ocAlarm: assert property (p_ocAlarm) else $error("oc alarm late");
  property p_ocFault;
    crit.fanFault |-> ##2 outs.ocFault;
  endproperty
  a_ocFault: assert property (p_ocFault) else $error("oc fault late");
  property p_afEarly;
    !flowOut |=> !afFault;
  endproperty
  a_afEarly: assert property (p_afEarly) else $error("airflow early");
  property p_tol;
    (afSw[1:0] == 2'b00 && flowDevPct == 8'h14) |-> !flowOut;
  endproperty
  a_tol: assert property (p_tol) else $error("window wrong");
  property p_dly;
    (afSw[3:2] == 2'b11 && flowOut) |-> u_afTimer.limit == TW'(AF_DLY3);
  endproperty
  a_dly: assert property (p_dly) else $error("delay wrong");
  property p_follow;
    (!relSw[0] ##0 s_alarmGone) |=> !outs.ocAlarm;
  endproperty
  a_follow: assert property (p_follow) else $error("alarm stuck");
  property p_hold;
    (relSw[0] && alarmSt && !clrAll && $stable(relSw)) |=> alarmSt;
  endproperty
  a_hold: assert property (p_hold) else $error("latch lost");
  property p_clear;
    ((relSw[0] && !crit.alarm) and s_clear) |=> !alarmSt;
  endproperty
  a_clear: assert property (p_clear) else $error("clear ignored");
  property p_alt;
    relSw[3] |-> relayMap[0] == alarmSt && relayMap[4] == faultSt;
  endproperty
  a_alt: assert property (p_alt) else $error("alt map wrong");
  property p_def;
    !relSw[3] |-> relayMap[2:0] == preSt && relayMap[3] == sensAny;
  endproperty
  a_def: assert property (p_def) else $error("default map wrong");
  property p_agg;
    crit.clockFault |-> faultCond;
  endproperty
  a_agg: assert property (p_agg) else $error("fault not merged");
  property p_inv;
    invFault |-> invFlash && comboBad;
  endproperty
  a_inv: assert property (p_inv) else $error("fault before flash");
endmodule
`default_nettype wire

// file: logic/delay_timer.sv
`timescale 1ns/1ps
`default_nettype none
// Counts millisecond ticks while run holds; restarts when run drops
module delay_timer (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Control
  input wire logic tick,
  input wire logic run,
  input wire logic [alarm_cfg_pkg::TMR_W-1:0] limit,
  // Result
  output logic expired
);
  logic [alarm_cfg_pkg::TMR_W-1:0] count_r;  // Elapsed ms
  logic [alarm_cfg_pkg::TMR_W-1:0] count_nxt;

  // Saturates at the limit so a long condition never wraps
  always_comb begin
    count_nxt = count_r;
    if (!run) begin
      count_nxt = '0;
    end else if (tick && !expired) begin
      count_nxt = count_r + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end

  // Expires once limit ticks are counted; the first tick may come at once, so up to one tick early
  assign expired = run && (count_r >= limit);
endmodule
`default_nettype wire

// file: logic/latch_cell.sv
`timescale 1ns/1ps
`default_nettype none
// State that either follows its cause or holds until cleared
module latch_cell #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Control
  input wire logic latchEn,
  input wire logic clr,
  input wire logic [W-1:0] cond,
  // State
  output logic [W-1:0] state
);
  logic [W-1:0] state_r;
  logic [W-1:0] state_nxt;

  // A cause present during a clear keeps the state set
  always_comb begin
    if (latchEn) begin
      state_nxt = cond | (state_r & {W{~clr}});
    end else begin
      state_nxt = cond;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign state = state_r;
endmodule
`default_nettype wire

// file: verification/alarm_fault_output_config_tb.sv
`timescale 1ns/1ps
`default_nettype none
module alarm_fault_output_config_tb;
  // ----------------------------------------
  // Shortened timing: ticks, delays in ticks
  // ----------------------------------------
  localparam int TK = 4;
  localparam int D0 = 3;
  localparam int D1 = 6;
  localparam int D2 = 10;
  localparam int D3 = 1;
  localparam int I1 = 3;
  localparam int I2 = 4;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic sysClk = 1'b0;
  logic rstN = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  alarm_cfg_pkg::crit_t crit = '0;
  logic [7:0] flowDevPct = 8'h00;
  logic comboBad = 1'b0;
  logic resetReq = 1'b0;
  logic extReset;
  logic [7:0] seen; // Outputs the panel has seen
  alarm_cfg_pkg::outs_t outs;
  logic irq;
  logic [31:0] rdData; // Last read word
  logic rdErr; // Last error response
  int mismatches = 0;
  int totalChecks = 0;

  always #4 sysClk = ~sysClk;

  alarm_fault_output_config #(.TICK_CYCLES(TK), .AF_DLY0(D0),
    .AF_DLY1(D1), .AF_DLY2(D2), .AF_DLY3(D3), .INV_DLY1(I1),
    .INV_DLY2(I2)) DUT (.sys_clk(sysClk), .rst_n(rstN), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .crit(crit),
    .flowDevPct(flowDevPct), .comboBad(comboBad), .extReset(extReset),
    .outs(outs), .irq(irq));

  panel_model panel (.sys_clk(sysClk), .outs(outs), .resetReq(resetReq),
    .extReset(extReset), .seen(seen));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic endOfTest();
    $display("checks %0d mismatches %0d", totalChecks, mismatches);
    if (mismatches == 0 && totalChecks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    totalChecks++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      mismatches++;
    end
  endtask

  // Waits a bounded number of edges for a masked output value
  task automatic waitFor(input logic useIrq, input logic [7:0] exp,
                         input logic [7:0] m, input int bound);
    int n;
    logic [7:0] got;
    n = 0;
    got = (useIrq ? {7'h00, irq} : 8'(outs)) & m;
    while (got !== exp && n < bound) begin
      @(posedge sysClk);
      n++;
      got = (useIrq ? {7'h00, irq} : 8'(outs)) & m;
    end
    chk(useIrq ? "irq" : "outs", {24'h0, exp}, {24'h0, got});
    if (got !== exp) begin
      endOfTest();
    end
  endtask

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sysClk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sysClk);
    penable <= 1'b1;
    do begin
      @(posedge sysClk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      mismatches++;
      endOfTest();
    end else begin
      rdData = prdata;
      rdErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  // Raises one criterion bit for three cycles
  task automatic pulse(input int i);
    @(posedge sysClk);
    crit <= alarm_cfg_pkg::crit_t'(13'h0001 << i);
    repeat (3) @(posedge sysClk);
    crit <= '0;
  endtask

  // Expected outputs for criterion bit i in either relay mapping
  function automatic logic [7:0] expMap(input int i, input int alt);
    if (i == 12) return alt ? 8'h9e : 8'h80;
    if (i >= 9) return alt ? 8'h00 : 8'h02 << (i - 9);
    if (alt) return 8'h78;
    if (i >= 6) return 8'h50;
    if (i >= 3) return 8'h60;
    return 8'h40;
  endfunction

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic tRegs();
    logic [31:0] sw [4];
    logic fix [4];
    sw = '{32'h1a00, 32'hcf00, 32'h1900, 32'hdf00};
    fix = '{1'b1, 1'b1, 1'b0, 1'b0};
    apb(1'b0, alarm_cfg_pkg::ADDR_CONFIG, 32'h0);
    chk("config", 32'h0, rdData);
    apb(1'b0, alarm_cfg_pkg::ADDR_INT_MASK, 32'h0);
    chk("intMask", 32'h0, rdData);
    apb(1'b0, 8'h20, 32'h0);
    chk("slvErr", 32'h1, {31'h0, rdErr});
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, alarm_cfg_pkg::ADDR_CONFIG, sw[i]);
      apb(1'b0, alarm_cfg_pkg::ADDR_STATE, 32'h0);
      chk("fixedSet", {31'h0, fix[i]}, {31'h0, rdData[12]});
    end
  endtask

  // Every criterion alone, default then alternative relay mapping
  task automatic tMap();
    for (int alt = 0; alt < 2; alt++) begin
      apb(1'b1, alarm_cfg_pkg::ADDR_CONFIG, alt ? 32'h80 : 32'h0);
      for (int i = 0; i < 13; i++) begin
        @(posedge sysClk);
        crit <= alarm_cfg_pkg::crit_t'(13'h0001 << i);
        // Outputs settle two edges on; a zero pattern is then checked too
        repeat (3) @(posedge sysClk);
        waitFor(1'b0, expMap(i, alt), 8'hff, 8);
        crit <= '0;
        waitFor(1'b0, 8'h00, 8'hff, 8);
      end
    end
  endtask

  // Latched states hold after the cause, cleared by command or input
  task automatic tLatch();
    apb(1'b1, alarm_cfg_pkg::ADDR_CONFIG, 32'h70);
    pulse(12);
    repeat (10) @(posedge sysClk);
    waitFor(1'b0, 8'h80, 8'hc0, 1);
    apb(1'b1, alarm_cfg_pkg::ADDR_CMD, 32'h1);
    waitFor(1'b0, 8'h00, 8'hc0, 8);
    pulse(8);
    repeat (10) @(posedge sysClk);
    waitFor(1'b0, 8'h40, 8'hc0, 1);
    resetReq <= 1'b1;
    @(posedge sysClk);
    resetReq <= 1'b0;
    waitFor(1'b0, 8'h00, 8'hc0, 16);
    pulse(9);
    repeat (10) @(posedge sysClk);
    waitFor(1'b0, 8'h02, 8'h02, 1);
    apb(1'b1, alarm_cfg_pkg::ADDR_CMD, 32'h1);
    waitFor(1'b0, 8'h00, 8'h02, 8);
  endtask

  // Each tolerance at its edge, each delay at its bounds
  task automatic tAir();
    int tol [4];
    int dly [4];
    tol = '{20, 50, 30, 10};
    dly = '{D0, D2, D1, D3};
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, alarm_cfg_pkg::ADDR_CONFIG, 32'(k * 5));
      @(posedge sysClk);
      flowDevPct <= 8'(tol[k]);
      repeat ((dly[k] + 2) * TK) @(posedge sysClk);
      waitFor(1'b0, 8'h00, 8'h40, 1);
      flowDevPct <= 8'(tol[k] + 1);
      repeat ((dly[k] - 1) * TK) @(posedge sysClk);
      waitFor(1'b0, 8'h00, 8'h40, 1);
      waitFor(1'b0, 8'h60, 8'h60, 3 * TK + 6);
      flowDevPct <= 8'h00;
      waitFor(1'b0, 8'h00, 8'h60, 8);
    end
  endtask

  // Invalid combination: flash after one delay, fault after another
  task automatic tInv();
    apb(1'b1, alarm_cfg_pkg::ADDR_CONFIG, 32'h0);
    comboBad <= 1'b1;
    repeat ((I1 - 1) * TK - 1) @(posedge sysClk);
    waitFor(1'b0, 8'h00, 8'h41, 1);
    waitFor(1'b0, 8'h01, 8'h41, 2 * TK + 6);
    repeat ((I2 - 1) * TK - 1) @(posedge sysClk);
    waitFor(1'b0, 8'h01, 8'h41, 1);
    waitFor(1'b0, 8'h41, 8'h41, 2 * TK + 6);
    comboBad <= 1'b0;
    waitFor(1'b0, 8'h00, 8'h41, 8);
    apb(1'b1, alarm_cfg_pkg::ADDR_INT_STAT, 32'h1f);
  endtask

  // Interrupt raised, cleared by writing one, then held off by the mask
  task automatic tIrq();
    apb(1'b1, alarm_cfg_pkg::ADDR_INT_STAT, 32'h1f);
    apb(1'b1, alarm_cfg_pkg::ADDR_INT_MASK, 32'h1);
    pulse(12);
    waitFor(1'b1, 8'h01, 8'h01, 8);
    apb(1'b0, alarm_cfg_pkg::ADDR_INT_STAT, 32'h0);
    chk("intStat", 32'h1, rdData & 32'h1f);
    apb(1'b1, alarm_cfg_pkg::ADDR_INT_STAT, 32'h1);
    waitFor(1'b1, 8'h00, 8'h01, 4);
    apb(1'b1, alarm_cfg_pkg::ADDR_INT_MASK, 32'h0);
    pulse(8);
    repeat (6) @(posedge sysClk);
    waitFor(1'b1, 8'h00, 8'h01, 1);
    apb(1'b0, alarm_cfg_pkg::ADDR_INT_STAT, 32'h0);
    chk("intStat", 32'h2, rdData & 32'h1f);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge sysClk);
    rstN <= 1'b1;
    tRegs();
    tMap();
    tLatch();
    tAir();
    tInv();
    tIrq();
    chk("seen", 32'hff, {24'h0, seen});
    endOfTest();
  end
endmodule
`default_nettype wire

// file: verification/panel_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Far side: panel output and relay module
// ----------------------------------------
// Watches the outputs and pulses the reset input on request, the way a
// panel control output would; it holds the input high for PULSE_CYC cycles after the last request
module panel_model #(
  parameter int PULSE_CYC = 3 // Reset pulse length in cycles
) (
  // Clock
  input wire logic sys_clk,
  // Observed outputs
  input wire alarm_cfg_pkg::outs_t outs,
  // Bench control
  input wire logic resetReq,
  // Reset input of the block
  output logic extReset,
  // Sticky record of every output that ever triggered
  output logic [7:0] seen
);
  int cnt = 0; // Remaining pulse cycles
  logic [7:0] seen_r = 8'h00; // Every output that ever triggered

  // Pulse counter and sticky record; plain always keeps the start values
  always @(posedge sys_clk) begin
    seen_r <= seen_r | outs;
    if (resetReq) begin
      cnt <= PULSE_CYC;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end

  assign extReset = (cnt > 0);
  assign seen = seen_r;
endmodule
`default_nettype wire
